/* File: usb_port_fault_flags.sv */
// fault flag registers, mask registers and interrupt request of the port
// How it works
// [R1] secondary fault register at 0xC is read only, one event flag per bit
// [R2] a flag reaches the interrupt only when its mask bit is set
// [R3] bits 3,2,1 set from bus sense monitors, read clears only if resolved
// [R4] bit 0 set on die over-temperature, read clears only if resolved
// [R5] cable supply overcurrent counted only while supply drives a config pin
// [R6] overcurrent on the unsupplied config pin is ignored
// [R7] reading clears overcurrent flag only once condition has gone
// [R8] interrupt is OR of masked flags, drops when all masked flags clear
`timescale 1ns/10ps
module usb_port_fault_flags (
    input wire logic CLK,
    input wire logic RST_N,
    input fault_flags_pkg::reg_req_type REQ,
    input fault_flags_pkg::monitor_type MON,
    output logic [7:0] RDATA,
    output logic RVALID,
    output logic IRQ
);
    import fault_flags_pkg::*;

    monitor_type mon_s1_ff;
    monitor_type mon_s2_ff;
    logic [7:0] pri_cond;
    logic [7:0] sec_cond;
    logic [7:0] pri_flags;
    logic [7:0] sec_flags;
    logic pri_clr;
    logic sec_clr;
    logic cable_oc;
    logic [7:0] mask_pri_ff;
    logic [7:0] nxt_mask_pri;
    logic [7:0] mask_sec_ff;
    logic [7:0] nxt_mask_sec;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic irq_ff;
    logic nxt_irq;
    logic rd_req;

    // analog monitors are asynchronous to the clock
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mon_s1_ff <= '0;
            mon_s2_ff <= '0;
        end else begin
            mon_s1_ff <= MON;
            mon_s2_ff <= mon_s1_ff;
        end
    end

    always_comb begin
        // only the supplied pin counts
        cable_oc = (mon_s2_ff.supply_on_cc1 & mon_s2_ff.cable_oc_cc1)
            | (mon_s2_ff.supply_on_cc2 & mon_s2_ff.cable_oc_cc2); // [R5] [R6]
        pri_cond = 8'h00;
        pri_cond[PRI_BIT_OVER] = mon_s2_ff.bus_overvoltage; // [R3]
        pri_cond[PRI_BIT_UNDER] = mon_s2_ff.bus_undervoltage; // [R3]
        pri_cond[PRI_BIT_SHORT] = mon_s2_ff.bus_short_ground; // [R3]
        pri_cond[PRI_BIT_THERMAL] = mon_s2_ff.thermal_shutdown; // [R4]
        sec_cond = 8'h00;
        sec_cond[SEC_BIT_CABLE_OC] = cable_oc;
        sec_cond[SEC_BIT_DATA_LINE_OVERVOLTAGE_FLAG] = mon_s2_ff.data_line_overvoltage;
        sec_cond[SEC_BIT_INPUT_OV] = mon_s2_ff.input_overvoltage;
        sec_cond[SEC_BIT_THERM_WARN] = mon_s2_ff.thermal_warning;
        sec_cond[SEC_BIT_SUPPLY_ERR] = mon_s2_ff.supply_error;
        sec_cond[SEC_BIT_PREBIAS] = mon_s2_ff.bus_prebias;
    end

    assign rd_req = REQ.sel & REQ.rd;
    assign pri_clr = rd_req & (REQ.addr == ADDR_PRIMARY); // [R3] [R4]
    assign sec_clr = rd_req & (REQ.addr == ADDR_SECONDARY); // [R7]

    sticky_flag_bank #(
        .WIDTH(8)
    ) u_primary (
        .clk(CLK),
        .rst_n(RST_N),
        .cond(pri_cond),
        .rd_clr(pri_clr),
        .flags(pri_flags)
    );

    sticky_flag_bank #(
        .WIDTH(8)
    ) u_secondary (
        .clk(CLK),
        .rst_n(RST_N),
        .cond(sec_cond),
        .rd_clr(sec_clr),
        .flags(sec_flags)
    );

    always_comb begin
        nxt_mask_pri = mask_pri_ff;
        nxt_mask_sec = mask_sec_ff;
        // flag registers ignore writes
        if (REQ.sel && REQ.wr) begin // [R1]
            if (REQ.addr == ADDR_MASK_PRI) begin
                nxt_mask_pri = REQ.wdata;
            end
            if (REQ.addr == ADDR_MASK_SEC) begin
                nxt_mask_sec = REQ.wdata;
            end
        end
        nxt_rvalid = rd_req;
        nxt_rdata = READ_IDLE;
        if (rd_req) begin
            case (REQ.addr)
                ADDR_PRIMARY: nxt_rdata = pri_flags;
                ADDR_SECONDARY: nxt_rdata = sec_flags; // [R1]
                ADDR_MASK_PRI: nxt_rdata = mask_pri_ff;
                ADDR_MASK_SEC: nxt_rdata = mask_sec_ff;
                default: nxt_rdata = READ_IDLE;
            endcase
        end
        nxt_irq = |(pri_flags & mask_pri_ff) | |(sec_flags & mask_sec_ff); // [R2] [R8]
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mask_pri_ff <= RESET_MASK;
            mask_sec_ff <= RESET_MASK;
            rdata_ff <= READ_IDLE;
            rvalid_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            mask_pri_ff <= nxt_mask_pri;
            mask_sec_ff <= nxt_mask_sec;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            irq_ff <= nxt_irq;
        end
    end

    assign RDATA = rdata_ff;
    assign RVALID = rvalid_ff;
    assign IRQ = irq_ff;
endmodule : usb_port_fault_flags

/* File: fault_flags_pkg.sv */
// constants and types for the port fault flag block
package fault_flags_pkg;
    localparam logic [7:0] ADDR_PRIMARY = 8'h0B;
    localparam logic [7:0] ADDR_SECONDARY = 8'h0C;
    localparam logic [7:0] ADDR_MASK_PRI = 8'h1B;
    localparam logic [7:0] ADDR_MASK_SEC = 8'h1C;
    localparam logic [7:0] RESET_FLAGS = 8'h00;
    localparam logic [7:0] RESET_MASK = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;
    localparam int PRI_BIT_THERMAL = 0;
    localparam int PRI_BIT_SHORT = 1;
    localparam int PRI_BIT_UNDER = 2;
    localparam int PRI_BIT_OVER = 3;
    localparam int SEC_BIT_CABLE_OC = 0;
    localparam int SEC_BIT_DATA_LINE_OVERVOLTAGE_FLAG = 1;
    localparam int SEC_BIT_INPUT_OV = 2;
    localparam int SEC_BIT_THERM_WARN = 3;
    localparam int SEC_BIT_SUPPLY_ERR = 4;
    localparam int SEC_BIT_PREBIAS = 5;
    localparam int PRI_USED = 4;
    localparam int SEC_USED = 6;

    typedef struct packed {
        logic sel;
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic bus_overvoltage;
        logic bus_undervoltage;
        logic bus_short_ground;
        logic thermal_shutdown;
        logic cable_oc_cc1;
        logic cable_oc_cc2;
        logic supply_on_cc1;
        logic supply_on_cc2;
        logic data_line_overvoltage;
        logic input_overvoltage;
        logic thermal_warning;
        logic supply_error;
        logic bus_prebias;
    } monitor_type;
endpackage : fault_flags_pkg

/* File: sticky_flag_bank.sv */
// row of sticky flags, set by condition, cleared on read once resolved
`timescale 1ns/10ps
module sticky_flag_bank #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] cond,
    input wire logic rd_clr,
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] flags_ff;
    logic [WIDTH-1:0] nxt_flags;

    always_comb begin
        // set wins; read clears only bits whose condition is gone
        nxt_flags = flags_ff | cond;
        if (rd_clr) begin
            nxt_flags = cond;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign flags = flags_ff;
endmodule : sticky_flag_bank

/* File: usb_port_fault_flags_sva.sv */
// checker for the port fault flag block
`timescale 1ns/10ps
module usb_port_fault_flags_sva (
    input wire logic CLK,
    input wire logic RST_N,
    input fault_flags_pkg::reg_req_type REQ,
    input fault_flags_pkg::monitor_type MON,
    input wire logic [7:0] RDATA,
    input wire logic RVALID,
    input wire logic IRQ
);
    import fault_flags_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic rd_p;
    logic rd_s;
    logic no_oc;
    assign rd_p = REQ.sel && REQ.rd && REQ.addr == ADDR_PRIMARY;
    assign rd_s = REQ.sel && REQ.rd && REQ.addr == ADDR_SECONDARY;
    assign no_oc = !(MON.cable_oc_cc1 && MON.supply_on_cc1) && !(MON.cable_oc_cc2 && MON.supply_on_cc2);
    property p_rv; REQ.sel && REQ.rd |=> RVALID; endproperty
    a_rv: assert property (p_rv) else $error("no answer");
    property p_idle; !RVALID |-> RDATA == READ_IDLE; endproperty
    a_idle: assert property (p_idle) else $error("idle data");
    property p_sec; rd_s |=> RDATA[7:6] == 2'h0; endproperty
    a_sec: assert property (p_sec) else $error("unused bits");
    property p_fall; $fell(IRQ) |-> $past(REQ.sel && (REQ.rd || REQ.wr), 2); endproperty
    a_fall: assert property (p_fall) else $error("irq drop");
    property p_ov; MON.bus_overvoltage [*4] ##0 rd_p |=> RDATA[PRI_BIT_OVER]; endproperty
    a_ov: assert property (p_ov) else $error("overvoltage");
    property p_thm; MON.thermal_shutdown [*4] ##0 rd_p |=> RDATA[PRI_BIT_THERMAL]; endproperty
    a_thm: assert property (p_thm) else $error("thermal");
    property p_oc; (!no_oc) [*4] ##0 rd_s |=> RDATA[SEC_BIT_CABLE_OC]; endproperty
    a_oc: assert property (p_oc) else $error("overcurrent");
    property p_clr; no_oc [*4] ##0 rd_s ##1 no_oc ##1 rd_s |=> !RDATA[SEC_BIT_CABLE_OC]; endproperty
    a_clr: assert property (p_clr) else $error("oc clear");
endmodule : usb_port_fault_flags_sva
bind usb_port_fault_flags usb_port_fault_flags_sva i_usb_port_fault_flags_sva (.CLK(CLK), .RST_N(RST_N),
    .REQ(REQ), .MON(MON), .RDATA(RDATA), .RVALID(RVALID), .IRQ(IRQ));

/* File: fault_host_model.sv */
// register host model
`timescale 1ns/10ps
module fault_host_model (
    input wire logic CLK,
    output fault_flags_pkg::reg_req_type REQ,
    input wire logic [7:0] RDATA,
    input wire logic RVALID
);
    import fault_flags_pkg::*;
    initial REQ = '{1'b0, 8'hFF, 1'b0, 1'b0, 8'hFF};
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d);
        @(posedge CLK) REQ <= '{1'b1, a, !w, w, wd};
        // idle lines show inverted values
        @(posedge CLK) REQ <= '{1'b0, ~a, 1'b0, 1'b0, ~wd};
        #1 d = (w || RVALID) ? RDATA : 8'hXX;
    endtask : xfer
endmodule : fault_host_model

/* File: usb_port_fault_flags_tb_top.sv */
// testbench for the port fault flag block
`timescale 1ns/10ps
module usb_port_fault_flags_tb_top;
    import fault_flags_pkg::*;
    logic CLK = 0;
    logic RST_N = 0;
    reg_req_type REQ;
    monitor_type MON = '0;
    logic [7:0] RDATA;
    logic RVALID;
    logic IRQ;
    logic [7:0] d;
    int n_errors = 0;
    int n_tests = 0;
    always #2.5 CLK = ~CLK;
    fault_host_model i_fault_host_model (.CLK(CLK), .REQ(REQ), .RDATA(RDATA), .RVALID(RVALID));
    usb_port_fault_flags i_usb_port_fault_flags (.CLK(CLK), .RST_N(RST_N), .REQ(REQ), .MON(MON),
        .RDATA(RDATA), .RVALID(RVALID), .IRQ(IRQ));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [7:0] a, input logic [7:0] exp);
        i_fault_host_model.xfer(1'b0, a, 8'h00, d);
        chk(d, exp);
    endtask : rd
    task mon(input monitor_type m);
        @(posedge CLK) MON <= m;
        repeat (5) @(posedge CLK);
    endtask : mon
    task t_rst;
        rd(ADDR_PRIMARY, RESET_FLAGS);
        rd(ADDR_SECONDARY, RESET_FLAGS);
        rd(ADDR_MASK_SEC, RESET_MASK);
        rd(ADDR_MASK_PRI, RESET_MASK);
        rd(8'h55, READ_IDLE);
    endtask : t_rst
    task t_stk;
        mon(13'h1E1F); // all bus, thermal and secondary monitors except overcurrent
        rd(ADDR_PRIMARY, 8'h0F);
        i_fault_host_model.xfer(1'b1, ADDR_SECONDARY, 8'h00, d);
        rd(ADDR_SECONDARY, 8'h3E);
        rd(ADDR_PRIMARY, 8'h0F);
        mon(13'h0000);
        rd(ADDR_PRIMARY, 8'h0F);
        rd(ADDR_PRIMARY, 8'h00);
        rd(ADDR_SECONDARY, 8'h3E);
        rd(ADDR_SECONDARY, 8'h00);
    endtask : t_stk
    task t_oc;
        mon(13'h0120); // overcurrent on cc1, supply on cc2
        rd(ADDR_SECONDARY, 8'h00);
        mon(13'h00A0); // overcurrent and supply on cc2
        rd(ADDR_SECONDARY, 8'h01);
        rd(ADDR_SECONDARY, 8'h01);
        mon(13'h0000);
        rd(ADDR_SECONDARY, 8'h01);
        rd(ADDR_SECONDARY, 8'h00);
    endtask : t_oc
    task t_irq;
        mon(13'h0008); // input overvoltage
        @(negedge CLK);
        chk({7'h00, IRQ}, 8'h00);
        i_fault_host_model.xfer(1'b1, ADDR_MASK_SEC, 8'h04, d);
        repeat (2) @(negedge CLK);
        chk({7'h00, IRQ}, 8'h01);
        rd(ADDR_MASK_SEC, 8'h04);
        mon(13'h0000);
        @(negedge CLK);
        chk({7'h00, IRQ}, 8'h01);
        rd(ADDR_SECONDARY, 8'h04);
        repeat (2) @(negedge CLK);
        chk({7'h00, IRQ}, 8'h00);
    endtask : t_irq
    task test_done;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    initial begin
        repeat (4) @(posedge CLK);
        RST_N <= 1'b1;
        t_rst();
        t_stk();
        t_oc();
        t_irq();
        test_done();
    end
endmodule : usb_port_fault_flags_tb_top
